// ---- src/cbl_config_loader.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cbl_consts.svh"

module cbl_config_loader
#(
   parameter int ADDR_W = `CBL_ADDR_W   // CPU data address width
)
(
   input  wire logic              clk_in,             // System clock
   input  wire logic              rst_n_in,           // Async reset, active low
   // Flash byte fetch during load
   output logic                   cfg_rd_out,         // Fetch strobe
   output logic                   cfg_sel_out,        // 0 = byte zero, 1 = byte one
   input  wire logic [7:0]        cfg_data_in,        // Flash byte, valid while strobe is high
   // Decoded settings
   output cbl_pkg::cbl_clk_src_type cpu_clock_source_select_out, // Oscillator source
   output logic                   internal_rc_frequency_select_out, // 1 = 22.1184 MHz
   output logic                   crystal_range_select_out, // 1 = above 24 MHz
   output logic                   cfg_valid_out,      // Settings loaded
   // PWM pin float control
   input  wire logic [7:0]        port_output_mode_in, // Per-pin drive enable from mode reg
   output logic [7:0]             pwm_pin_oe_out,     // Final PWM pin drive enable
   output logic                   even_pwm_hiz_flag_out, // Control three even flag
   output logic                   odd_pwm_hiz_flag_out,  // Control three odd flag
   // Programming tool access check
   input  wire logic              tool_req_in,        // Tool access request, async
   input  wire cbl_pkg::cbl_path_type tool_path_in,   // Requesting path
   input  wire logic              tool_data_area_in,  // 1 = data flash, 0 = program flash
   input  wire logic              tool_is_erase_in,   // Bank/area erase request
   input  wire logic              tool_is_read_in,    // Read request
   output logic                   tool_grant_out,     // Access allowed
   output logic                   tool_deny_out,      // Access refused
   output logic                   lock_illegal_out,   // Unsupported lock combination
   // CPU external-data read port
   input  wire logic              cpu_rd_in,          // Read strobe
   input  wire logic [ADDR_W-1:0] cpu_addr_in,        // Read address
   output logic [7:0]             cpu_rdata_out,      // Read data
   output logic                   cpu_hit_out         // Address was a config byte
);

   logic                    rst_meta_r;
   logic                    rst_sync_n_r;
   logic                    tool_req_s;
   cbl_pkg::cbl_state_type  state_r;
   cbl_pkg::cbl_state_type  state_nxt;
   logic [7:0]              cfg0_r;
   logic [7:0]              cfg0_nxt;
   logic [7:0]              cfg1_r;
   logic [7:0]              cfg1_nxt;
   logic                    rd_nxt;
   logic                    sel_nxt;
   logic                    pend_r;
   logic                    pend_nxt;
   localparam int           QUAL_W = 5;          // Path, area, erase, read
   logic [QUAL_W-1:0]       tool_qual_raw;
   logic [QUAL_W-1:0]       tool_qual_s;
   logic [1:0]              tool_path_s;
   logic                    tool_area_s;
   logic                    tool_erase_s;
   logic                    tool_read_s;
   logic                    prog_ok;
   logic                    data_ok;
   logic                    grant_nxt;
   logic                    deny_nxt;
   logic [7:0]              oe_nxt;
   logic [7:0]              rdata_nxt;
   logic                    hit_nxt;

   // Reset release through two flops
   // Entry is immediate; release waits two edges so no flop sees a runt
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta_r   <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r   <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   // Tool request arrives from a pin
   cbl_bit_sync u_tool_sync
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_sync_n_r),
      .d_in     (tool_req_in),
      .q_out    (tool_req_s)
   );

   // Qualifiers pass the same two stages as the request, so all arrive together
   // Limitation: a tool must settle them no later than it raises the request
   assign tool_qual_raw = {tool_path_in, tool_data_area_in, tool_is_erase_in, tool_is_read_in};
   for (genvar g = 0; g < QUAL_W; g++)
   begin : g_qual_sync
      cbl_bit_sync u_qual_sync
      (
         .clk_in   (clk_in),
         .rst_n_in (rst_sync_n_r),
         .d_in     (tool_qual_raw[g]),
         .q_out    (tool_qual_s[g])
      );
   end

   // Split the synchronised qualifiers back into fields
   assign {tool_path_s, tool_area_s, tool_erase_s, tool_read_s} = tool_qual_s;

   // Load sequencer: fetch both bytes once after reset, then hold
   // Each byte costs a strobe cycle and a take cycle
   always_comb
   begin
      state_nxt = state_r;
      cfg0_nxt  = cfg0_r;
      cfg1_nxt  = cfg1_r;
      rd_nxt    = 1'b0;
      sel_nxt   = cfg_sel_out;
      pend_nxt  = pend_r;
      unique case (state_r)
         cbl_pkg::CBL_ST_FETCH0:
         begin
            rd_nxt  = !pend_r;
            sel_nxt = 1'b0;
            pend_nxt = 1'b1;
            if (pend_r)
            begin
               cfg0_nxt  = cfg_data_in;
               state_nxt = cbl_pkg::CBL_ST_FETCH1;
               pend_nxt  = 1'b0;
            end
         end
         cbl_pkg::CBL_ST_FETCH1:
         begin
            rd_nxt  = !pend_r;
            sel_nxt = 1'b1;
            pend_nxt = 1'b1;
            if (pend_r)
            begin
               cfg1_nxt  = cfg_data_in;
               state_nxt = cbl_pkg::CBL_ST_RUN;
               pend_nxt  = 1'b0;
            end
         end
         cbl_pkg::CBL_ST_RUN:
         begin
            // Held until the next reset; program cannot alter it
            state_nxt = cbl_pkg::CBL_ST_RUN;
         end
         default:
         begin
            state_nxt = cbl_pkg::CBL_ST_FETCH0;
            pend_nxt  = 1'b0;
         end
      endcase
   end

   // Sequencer registers; erased value until loaded, locks kept closed by the RUN check
   always_ff @(posedge clk_in or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         state_r     <= cbl_pkg::CBL_ST_FETCH0;
         cfg0_r      <= `CBL_CFG_ERASED;
         cfg1_r      <= `CBL_CFG_ERASED;
         cfg_rd_out  <= 1'b0;
         cfg_sel_out <= 1'b0;
         pend_r      <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         cfg0_r      <= cfg0_nxt;
         cfg1_r      <= cfg1_nxt;
         cfg_rd_out  <= rd_nxt;
         cfg_sel_out <= sel_nxt;
         pend_r      <= pend_nxt;
      end
   end

   // Lock decode, closed until bytes are loaded
   // Only a data-area erase looks at which tool path is asking
   always_comb
   begin
      prog_ok   = (state_r == cbl_pkg::CBL_ST_RUN)
                  && cfg1_r[`CBL_CFG1_PROG_LOCK];
      data_ok   = (state_r == cbl_pkg::CBL_ST_RUN)
                  && cfg1_r[`CBL_CFG1_DATA_LOCK];
      grant_nxt = 1'b0;
      deny_nxt  = 1'b0;
      if (tool_req_s && tool_path_s != cbl_pkg::CBL_PATH_NONE)
      begin
         if (tool_area_s)
         begin
            // Data area open when its bit is set; under program lock only ICP may erase it
            if (data_ok && !prog_ok && tool_erase_s)
               grant_nxt = (tool_path_s == cbl_pkg::CBL_PATH_ICP);
            else if (data_ok && !tool_erase_s)
               grant_nxt = 1'b1;
            else if (data_ok && prog_ok)
               grant_nxt = 1'b1;
            else
               grant_nxt = 1'b0;
         end
         else
         begin
            grant_nxt = prog_ok && data_ok;
            if (!prog_ok && tool_read_s)
               grant_nxt = 1'b0;
         end
         deny_nxt = !grant_nxt;
      end
   end

   // Pin float: forced high-impedance overrides the mode register
   // Gate uses the registered flag, one cycle behind a fresh load
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (i % 2 == 0)
            oe_nxt[i] = port_output_mode_in[i] && !even_pwm_hiz_flag_out;
         else
            oe_nxt[i] = port_output_mode_in[i] && !odd_pwm_hiz_flag_out;
      end
   end

   // CPU data move read of the two bytes
   // Unmapped addresses read as zero, so no other state leaks out
   always_comb
   begin
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
      if (cpu_rd_in && cpu_addr_in == ADDR_W'(`CBL_ADDR_CFG0))
      begin
         rdata_nxt = cfg0_r;
         hit_nxt   = 1'b1;
      end
      else if (cpu_rd_in && cpu_addr_in == ADDR_W'(`CBL_ADDR_CFG1))
      begin
         rdata_nxt = cfg1_r;
         hit_nxt   = 1'b1;
      end
   end

   // Output registers driven from held bytes
   // Settings follow the held bytes, never the live flash data
   always_ff @(posedge clk_in or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         cpu_clock_source_select_out      <= cbl_pkg::CBL_SRC_CRYSTAL;
         internal_rc_frequency_select_out <= 1'b1;
         crystal_range_select_out         <= 1'b0;
         cfg_valid_out                    <= 1'b0;
         even_pwm_hiz_flag_out            <= 1'b1;
         odd_pwm_hiz_flag_out             <= 1'b1;
         pwm_pin_oe_out                   <= 8'h00;
         tool_grant_out                   <= 1'b0;
         tool_deny_out                    <= 1'b0;
         lock_illegal_out                 <= 1'b0;
         cpu_rdata_out                    <= 8'h00;
         cpu_hit_out                      <= 1'b0;
      end
      else
      begin
         cpu_clock_source_select_out <= cbl_pkg::cbl_clk_src_type'(
            {cfg0_r[`CBL_CFG0_FOSC_HI], cfg0_r[`CBL_CFG0_FOSC_LO]});
         internal_rc_frequency_select_out <= cfg1_r[`CBL_CFG1_RC_FREQ];
         crystal_range_select_out         <= cfg1_r[`CBL_CFG1_XTAL_RANGE];
         cfg_valid_out                    <= (state_r == cbl_pkg::CBL_ST_RUN);
         // Flags reload on each reset since bytes are refetched
         even_pwm_hiz_flag_out <= cfg1_r[`CBL_CFG1_EVEN_HIZ];
         odd_pwm_hiz_flag_out  <= cfg1_r[`CBL_CFG1_ODD_HIZ];
         pwm_pin_oe_out        <= oe_nxt;
         tool_grant_out        <= grant_nxt;
         tool_deny_out         <= deny_nxt;
         // Unsupported pair flagged; tool must not program it
         lock_illegal_out <= (state_r == cbl_pkg::CBL_ST_RUN)
                             && cfg1_r[`CBL_CFG1_PROG_LOCK]
                             && !cfg1_r[`CBL_CFG1_DATA_LOCK];
         cpu_rdata_out    <= rdata_nxt;
         cpu_hit_out      <= hit_nxt;
      end
   end

endmodule // cbl_config_loader

`default_nettype wire

// ---- include/cbl_consts.svh ----
`ifndef CBL_CONSTS_SVH
`define CBL_CONSTS_SVH

// Flash addresses of the two configuration bytes
`define CBL_ADDR_CFG0        16'hfb00
`define CBL_ADDR_CFG1        16'hfb01
`define CBL_ADDR_W           16
// Field positions in configuration byte zero
`define CBL_CFG0_FOSC_LO     0
`define CBL_CFG0_FOSC_HI     1
// Field positions in configuration byte one
`define CBL_CFG1_PROG_LOCK   7
`define CBL_CFG1_DATA_LOCK   6
`define CBL_CFG1_RC_FREQ     5
`define CBL_CFG1_RSVD_HI     4
`define CBL_CFG1_XTAL_RANGE  3
`define CBL_CFG1_RSVD_LO     2
`define CBL_CFG1_EVEN_HIZ    1
`define CBL_CFG1_ODD_HIZ     0
// Erased-flash value used before the first sample completes
`define CBL_CFG_ERASED       8'hff
`define CBL_CNT_ZERO         2'h0
`define CBL_CNT_ONE          2'h1

`endif

// ---- include/cbl_pkg.sv ----
package cbl_pkg;

   // CPU clock source encodings
   typedef enum logic [1:0] {
      CBL_SRC_CRYSTAL  = 2'h0,
      CBL_SRC_INT_RC   = 2'h1,
      CBL_SRC_RESERVED = 2'h2,
      CBL_SRC_EXT_CLK  = 2'h3
   } cbl_clk_src_type;

   // Load sequencer states, Gray along the path
   typedef enum logic [1:0] {
      CBL_ST_FETCH0 = 2'h0,
      CBL_ST_FETCH1 = 2'h1,
      CBL_ST_RUN    = 2'h3
   } cbl_state_type;

   // Tool path that asks for a flash access
   typedef enum logic [1:0] {
      CBL_PATH_WRITER = 2'h0,
      CBL_PATH_ICP    = 2'h1,
      CBL_PATH_JTAG   = 2'h2,
      CBL_PATH_NONE   = 2'h3
   } cbl_path_type;

endpackage

// ---- src/cbl_bit_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for one level from outside the clock domain
module cbl_bit_sync
(
   input  wire logic clk_in,    // System clock
   input  wire logic rst_n_in,  // Async reset, active low
   input  wire logic d_in,      // Asynchronous level
   output logic      q_out      // Synchronised level
);

   logic meta_r;
   logic meta_nxt;
   logic q_nxt;

   // First stage read only by the second
   always_comb
   begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   // Register both stages
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_r <= 1'b0;
         q_out  <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_out  <= q_nxt;
      end
   end

endmodule // cbl_bit_sync

`default_nettype wire

// ---- tb/cbl_cfg_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cbl_consts.svh"

module cbl_cfg_asserts
#(
   parameter int ADDR_W = 16   // Address width
)
(
   input wire logic                    clk_in,                           // Clock
   input wire logic                    rst_n_in,                         // Reset
   input wire logic                    cfg_rd_out,                       // Fetch
   input wire logic                    cfg_sel_out,                      // Byte
   input wire cbl_pkg::cbl_clk_src_type cpu_clock_source_select_out,     // Source
   input wire logic                    internal_rc_frequency_select_out, // RC
   input wire logic                    crystal_range_select_out,         // Range
   input wire logic                    cfg_valid_out,                    // Loaded
   input wire logic [7:0]              port_output_mode_in,              // Mode
   input wire logic [7:0]              pwm_pin_oe_out,                   // Enable
   input wire logic                    even_pwm_hiz_flag_out,            // Even
   input wire logic                    odd_pwm_hiz_flag_out,             // Odd
   input wire logic                    tool_grant_out,                   // Grant
   input wire logic                    tool_deny_out,                    // Deny
   input wire logic                    lock_illegal_out,                 // Bad lock
   input wire logic                    cpu_rd_in,                        // Read
   input wire logic [ADDR_W-1:0]       cpu_addr_in,                      // Address
   input wire logic                    cpu_hit_out                       // Hit
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_fetch0;
      cfg_rd_out && !cfg_sel_out;
   endsequence
   sequence s_fetch1;
      cfg_rd_out && cfg_sel_out;
   endsequence

   a_fetch_order: assert property (s_fetch0 |-> ##2 s_fetch1 ##[1:2] cfg_valid_out)
      else $error("fetch order wrong");
   a_settings_hold: assert property (cfg_valid_out && $past(cfg_valid_out) |->
      $stable(cpu_clock_source_select_out) && $stable({internal_rc_frequency_select_out,
      crystal_range_select_out, even_pwm_hiz_flag_out, odd_pwm_hiz_flag_out}))
      else $error("settings moved while running");
   a_grant_exclusive: assert property (!(tool_grant_out && tool_deny_out))
      else $error("grant and deny together");
   a_preload_deny: assert property (!cfg_valid_out |-> !tool_grant_out)
      else $error("grant before load");
   a_illegal_deny: assert property (lock_illegal_out |-> !tool_grant_out)
      else $error("grant with bad lock");
   a_even_gate: assert property (cfg_valid_out && $past(cfg_valid_out) |->
      (pwm_pin_oe_out & 8'h55) == ($past(port_output_mode_in) & 8'h55
      & {8{!$past(even_pwm_hiz_flag_out)}}))
      else $error("even pin enable wrong");
   a_odd_gate: assert property (cfg_valid_out && $past(cfg_valid_out) |->
      (pwm_pin_oe_out & 8'haa) == ($past(port_output_mode_in) & 8'haa
      & {8{!$past(odd_pwm_hiz_flag_out)}}))
      else $error("odd pin enable wrong");
   a_cpu_hit: assert property (cfg_valid_out && cpu_rd_in |=> cpu_hit_out ==
      ($past(cpu_addr_in) == `CBL_ADDR_CFG0 || $past(cpu_addr_in) == `CBL_ADDR_CFG1))
      else $error("hit does not match address");
   a_cpu_idle: assert property (!cpu_rd_in |=> !cpu_hit_out)
      else $error("hit without read");
endmodule // cbl_cfg_asserts

bind cbl_config_loader cbl_cfg_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_in, .rst_n_in,
   .cfg_rd_out, .cfg_sel_out, .cpu_clock_source_select_out, .internal_rc_frequency_select_out,
   .crystal_range_select_out, .cfg_valid_out, .port_output_mode_in, .pwm_pin_oe_out,
   .even_pwm_hiz_flag_out, .odd_pwm_hiz_flag_out, .tool_grant_out, .tool_deny_out,
   .lock_illegal_out, .cpu_rd_in, .cpu_addr_in, .cpu_hit_out);

`default_nettype wire

// ---- tb/cbl_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module cbl_flash_model
(
   input  wire logic       clk_in,   // Clock
   input  wire logic       rd_in,    // Fetch strobe
   input  wire logic       sel_in,   // Byte select
   input  wire logic [7:0] byte0_in, // Stored byte zero
   input  wire logic [7:0] byte1_in, // Stored byte one
   output var  logic [7:0] data_out  // Flash data
);
   logic [7:0] idle_r = 8'h5a; // Pattern between fetches

   // Idle pattern flips each cycle so an early or late take shows up
   always @(posedge clk_in)
      idle_r <= ~idle_r;

   // Byte stands while the strobe does and is taken at the edge ending it
   always_comb
      data_out = rd_in ? (sel_in ? (byte1_in | 8'h14) : byte0_in) : idle_r;
endmodule // cbl_flash_model

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic                     clk_in = 1'b0, rst_n_in = 1'b0, req = 1'b0, area = 1'b0;
   logic                     ers = 1'b0, rdq = 1'b0, cpu_rd = 1'b0, e;
   logic                     rd, sel, rc, xtal, vld, ev, od, gr, dn, ill, hit;
   logic [7:0]               mode = 8'h00, b0 = 8'h00, b1 = 8'hff, fdata, oe, rdata;
   logic [15:0]              addr = 16'h0000;
   cbl_pkg::cbl_path_type    path = cbl_pkg::CBL_PATH_NONE;
   cbl_pkg::cbl_clk_src_type src;
   int                       n_errors = 0, n_compared = 0, i, k, p, op;

   // Free-running clock
   always #5 clk_in = ~clk_in;

   cbl_flash_model u_flash (.clk_in(clk_in), .rd_in(rd), .sel_in(sel), .byte0_in(b0),
      .byte1_in(b1), .data_out(fdata));

   cbl_config_loader DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_rd_out(rd),
      .cfg_sel_out(sel), .cfg_data_in(fdata), .cpu_clock_source_select_out(src),
      .internal_rc_frequency_select_out(rc), .crystal_range_select_out(xtal),
      .cfg_valid_out(vld), .port_output_mode_in(mode), .pwm_pin_oe_out(oe),
      .even_pwm_hiz_flag_out(ev), .odd_pwm_hiz_flag_out(od), .tool_req_in(req),
      .tool_path_in(path), .tool_data_area_in(area), .tool_is_erase_in(ers),
      .tool_is_read_in(rdq), .tool_grant_out(gr), .tool_deny_out(dn),
      .lock_illegal_out(ill), .cpu_rd_in(cpu_rd), .cpu_addr_in(addr),
      .cpu_rdata_out(rdata), .cpu_hit_out(hit));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Inputs always move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Reset, then wait for the load with a bound
   task automatic boot;
      rst_n_in = 1'b0;
      tick(2);
      chk({ev, od, rc}, 8'h07);
      rst_n_in = 1'b1;
      for (k = 0; k < 50 && vld !== 1'b1; k++)
         tick(1);
      if (vld !== 1'b1)
      begin
         n_errors++;
         close_out();
      end
      tick(1);
   endtask

   task automatic cpu_read(input logic [15:0] a, input logic [7:0] exp, input logic h);
      addr = a;
      cpu_rd = 1'b1;
      tick(1);
      chk({hit, rdata}, {h, exp});
      cpu_rd = 1'b0;
      tick(1);
   endtask

   // One tool access; held until the registered answer settles
   task automatic tool(input logic exp);
      path = cbl_pkg::cbl_path_type'(p);
      req = 1'b1;
      tick(4);
      chk({gr, dn}, {exp, !exp});
      req = 1'b0;
      tick(4);
   endtask

   // Each pass is a new reset with another lock pair and source
   initial
   begin
      void'($urandom(60416));
      for (i = 0; i < 4; i++)
      begin
         b0 = (8'($urandom) & 8'hfc) | 8'(i);
         b1 = 8'($urandom);
         b1[7:6] = 2'(3 - i);
         boot();
         chk(src, b0[1:0]);
         chk(rc, b1[5]);
         chk(xtal, b1[3]);
         chk({ev, od}, b1[1:0]);
         chk(ill, b1[7] & !b1[6]);
         cpu_read(16'hfb00, b0, 1'b1);
         cpu_read(16'hfb01, b1 | 8'h14, 1'b1);
         cpu_read(16'hfb02, 8'h00, 1'b0);
         mode = 8'($urandom);
         tick(2);
         chk(oe, mode & ~{4{b1[0], b1[1]}});
         for (k = 0; k < 18; k++)
         begin
            p = k % 3;
            op = k / 6;
            area = 1'((k / 3) % 2);
            rdq = (op == 0);
            ers = (op == 2);
            e = area ? (ers ? b1[6] & (b1[7] | p == 1) : b1[6]) : b1[7] & b1[6];
            tool(e);
         end
      end
      close_out();
   end
endmodule // tb

`default_nettype wire
